// *** design/rcr_pkg.sv ***
package rcr_pkg;

  // register indices; byte address is four times the index
  localparam int unsigned IDX_W           = 10;
  localparam logic [9:0]  IDX_CNT_A       = 10'h0B0;
  localparam logic [9:0]  IDX_CNT_B       = 10'h0B5;
  localparam logic [9:0]  IDX_CTRL0       = 10'h0BA;
  localparam logic [9:0]  IDX_CTRL1       = 10'h0BB;
  localparam int unsigned IDX_LSB         = 2;

  // converter_control_0 fields, and the converter_control_1 mode width
  localparam int unsigned RUN_BIT         = 0;
  localparam int unsigned ISEL_BIT        = 1;
  localparam int unsigned SUPPLY_BIT      = 2;
  localparam int unsigned MODE_W          = 4;

  // oscillation mode codes (converter_control_1)
  localparam logic [3:0]  MODE_EXT_IN0    = 4'h0;
  localparam logic [3:0]  MODE_REF_CH0    = 4'h1;
  localparam logic [3:0]  MODE_SNS_CH0    = 4'h2;
  localparam logic [3:0]  MODE_SER_CH0    = 4'h3;
  localparam logic [3:0]  MODE_CAP_CH0    = 4'h4;
  localparam logic [3:0]  MODE_REF_CH1    = 4'h5;
  localparam logic [3:0]  MODE_SNS_CH1    = 4'h6;
  localparam logic [3:0]  MODE_EXT_IN1    = 4'h7;

  // counter layouts and limits
  localparam int unsigned CNT_A_W         = 20;
  localparam int unsigned DIGITS          = 5;
  localparam logic [3:0]  DIGIT_MAX       = 4'h9;
  localparam logic [3:0]  TOP_DIGIT_MAX   = 4'h7;
  localparam int unsigned CNT_B_W         = 14;
  localparam logic [13:0] CNT_B_MAX       = 14'h3FFF;
  localparam logic [13:0] CNT_B_ONE       = 14'h0001;

  localparam logic [31:0] RESET_WORD      = 32'h0000_0000;
  localparam int unsigned HTRANS_ACT_BIT  = 1;
  localparam logic        HRESP_OKAY      = 1'b0;

  typedef struct packed {
    logic ref_res_ch0;
    logic sensor_res_ch0;
    logic series_res_ch0;
    logic ref_cap_ch0;
    logic sensor_cap_ch0;
    logic ref_res_ch1;
    logic sensor_res_ch1;
    logic ref_cap_ch1;
    logic ext_in_ch0;
    logic ext_in_ch1;
  } rcr_osc_drive_t;

  typedef enum logic [1:0] {
    BUS_IDLE    = 2'b00,
    BUS_RD_WAIT = 2'b01,
    BUS_RD_OUT  = 2'b11,
    BUS_WRITE   = 2'b10
  } rcr_bus_state_t;

endpackage

// *** design/rcr_edge_sync.sv ***
`timescale 1ns/1ns
module rcr_edge_sync (
  input  wire logic core_clk_i,
  input  wire logic arst_n_i,
  input  wire logic async_i,
  output logic      rise_o
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } rcr_sync_state_t;

  rcr_sync_state_t state_reg;
  rcr_sync_state_t state_next;

  always_comb
  begin
    state_next      = state_reg;
    state_next.meta = async_i;
    state_next.sync = state_reg.meta;
    state_next.last = state_reg.sync;
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  // rising edge seen only past the second stage
  assign rise_o = state_reg.sync & ~state_reg.last;

endmodule

// *** design/rcr_ratio_counter.sv ***
// Overview of operation
// [R01]: mode field picks oscillator resistor/capacitor pair.
// [R02]: select 0: counter A gates, B counts.
// [R03]: select 1: counter B gates, A counts.
// [R04]: software preloads A with 80000 minus gate.
// [R05]: software clears B before A-gated run.
// [R06]: software preloads B with 4000H minus gate.
// [R07]: software clears A before B-gated run.
// [R08]: software sets supply switch before run.
// [R09]: software waits 120 us before run.
// [R10]: preload, clear, mode in any order first.
// [R11]: count-on follows run; counting needs it.
// [R12]: A overflow ends A-gated run, raises irq.
// [R13]: A-gated: oscillator and B run with count-on.
// [R14]: B overflow ends B-gated run, raises irq.
// [R15]: B-gated: A counts clock from count-on.
// [R16]: software pairs reference and sensor runs.
// [R17]: counter A decade, wraps after 79999.
// [R18]: counter B 14-bit, wraps after 16383.
// [R19]: no conversion while supply switch is 0.
// [R20]: run bit reads back measurement in progress.
// [R21]: count-on drops with run; counters hold.
//
// Design decisions made here: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ns
module rcr_ratio_counter (
  input  wire logic               core_clk_i,
  input  wire logic               arst_n_i,
  input  wire logic               hsel_i,
  input  wire logic [31:0]        haddr_i,
  input  wire logic [1:0]         htrans_i,
  input  wire logic               hwrite_i,
  input  wire logic [2:0]         hsize_i,
  input  wire logic [31:0]        hwdata_i,
  input  wire logic               hready_i,
  output logic      [31:0]        hrdata_o,
  output logic                    hreadyout_o,
  output logic                    hresp_o,
  input  wire logic               rc_osc_clock_i,
  output rcr_pkg::rcr_osc_drive_t osc_drive_o,
  output logic                    osc_run_o,
  output logic                    count_on_o,
  output logic                    converter_irq_o
);

  typedef struct packed {
    rcr_pkg::rcr_bus_state_t bus_st;
    logic [9:0]              dp_idx;
    logic [31:0]             rdata;
    logic                    run;
    logic                    isel;
    logic                    supply;
    logic [3:0]              mode;
    logic [19:0]             cnt_a;
    logic [13:0]             cnt_b;
    logic                    count_on;
    logic                    irq;
    rcr_pkg::rcr_osc_drive_t drive;
  } rcr_state_t;

  rcr_state_t state_reg;
  rcr_state_t state_next;
  logic       osc_rise;

  rcr_edge_sync u_osc_sync (
    .core_clk_i (core_clk_i),
    .arst_n_i   (arst_n_i),
    .async_i    (rc_osc_clock_i),
    .rise_o     (osc_rise)
  );

  // decimal increment; low digits 0..9, top digit 0..7
  function automatic logic [19:0] bcd_inc(input logic [19:0] val);
    logic [19:0] res;
    logic        carry;
    res   = val;
    carry = 1'b1;
    for (int d = 0; d < rcr_pkg::DIGITS; d++)
    begin
      if (carry)
      begin
        if (res[d*4 +: 4] == ((d == rcr_pkg::DIGITS - 1) ? rcr_pkg::TOP_DIGIT_MAX : rcr_pkg::DIGIT_MAX))
          res[d*4 +: 4] = 4'h0;
        else
        begin
          res[d*4 +: 4] = res[d*4 +: 4] + 4'h1;
          carry         = 1'b0;
        end
      end
    end
    return res;
  endfunction

  function automatic logic bcd_is_max(input logic [19:0] val);
    logic m;
    m = (val[19:16] == rcr_pkg::TOP_DIGIT_MAX);
    for (int d = 0; d < rcr_pkg::DIGITS - 1; d++)
      m = m & (val[d*4 +: 4] == rcr_pkg::DIGIT_MAX);
    return m;
  endfunction

  function automatic rcr_pkg::rcr_osc_drive_t osc_decode(input logic [3:0] mode);
    rcr_pkg::rcr_osc_drive_t drv;
    drv = '0;
    unique case (mode)
      rcr_pkg::MODE_EXT_IN0: drv.ext_in_ch0 = 1'b1;
      rcr_pkg::MODE_REF_CH0:
      begin
        drv.ref_res_ch0 = 1'b1;
        drv.ref_cap_ch0 = 1'b1;
      end
      rcr_pkg::MODE_SNS_CH0:
      begin
        drv.sensor_res_ch0 = 1'b1;
        drv.ref_cap_ch0    = 1'b1;
      end
      rcr_pkg::MODE_SER_CH0:
      begin
        drv.series_res_ch0 = 1'b1;
        drv.ref_cap_ch0    = 1'b1;
      end
      rcr_pkg::MODE_CAP_CH0:
      begin
        drv.ref_res_ch0    = 1'b1;
        drv.sensor_cap_ch0 = 1'b1;
      end
      rcr_pkg::MODE_REF_CH1:
      begin
        drv.ref_res_ch1 = 1'b1;
        drv.ref_cap_ch1 = 1'b1;
      end
      rcr_pkg::MODE_SNS_CH1:
      begin
        drv.sensor_res_ch1 = 1'b1;
        drv.ref_cap_ch1    = 1'b1;
      end
      rcr_pkg::MODE_EXT_IN1: drv.ext_in_ch1 = 1'b1;
      // codes with the top bit set leave every pin idle
      default: drv = '0;
    endcase
    return drv;
  endfunction

  function automatic logic [31:0] read_mux(input logic [9:0] idx, input rcr_state_t s);
    logic [31:0] w;
    w = rcr_pkg::RESET_WORD;
    if (idx == rcr_pkg::IDX_CTRL0)
    begin
      w[rcr_pkg::RUN_BIT]    = s.run; // [R20]
      w[rcr_pkg::ISEL_BIT]   = s.isel;
      w[rcr_pkg::SUPPLY_BIT] = s.supply;
    end
    else if (idx == rcr_pkg::IDX_CTRL1)
      w[rcr_pkg::MODE_W-1:0] = s.mode;
    else if (idx == rcr_pkg::IDX_CNT_A)
      w[rcr_pkg::CNT_A_W-1:0] = s.cnt_a;
    else if (idx == rcr_pkg::IDX_CNT_B)
      w[rcr_pkg::CNT_B_W-1:0] = s.cnt_b;
    return w;
  endfunction

  always_comb
  begin
    logic count_en;
    logic ovf_a;
    logic ovf_b;
    logic gate_ovf;
    logic accept;
    state_next = state_reg;
    state_next.irq = 1'b0;
    count_en = state_reg.count_on & state_reg.run & state_reg.supply; // [R11] [R19]
    ovf_a    = count_en & bcd_is_max(state_reg.cnt_a); // [R17]
    ovf_b    = count_en & osc_rise & (state_reg.cnt_b == rcr_pkg::CNT_B_MAX); // [R18]
    gate_ovf = state_reg.isel ? ovf_b : ovf_a; // [R02] [R03]
    accept   = hsel_i & hready_i & htrans_i[rcr_pkg::HTRANS_ACT_BIT];

    // both counters run together; the select only picks the gate
    if (count_en)
    begin
      state_next.cnt_a = bcd_inc(state_reg.cnt_a); // [R15] [R17]
      if (osc_rise)
        state_next.cnt_b = state_reg.cnt_b + rcr_pkg::CNT_B_ONE; // [R13] [R18]
    end
    if (gate_ovf)
    begin
      state_next.run = 1'b0; // [R12] [R14]
      state_next.irq = 1'b1; // [R12] [R14]
    end

    unique case (state_reg.bus_st)
      rcr_pkg::BUS_RD_WAIT:
      begin
        state_next.rdata  = read_mux(state_reg.dp_idx, state_reg);
        state_next.bus_st = rcr_pkg::BUS_RD_OUT;
      end
      rcr_pkg::BUS_IDLE,
      rcr_pkg::BUS_RD_OUT,
      rcr_pkg::BUS_WRITE:
      begin
        // software write wins over the same-cycle hardware update
        if (state_reg.bus_st == rcr_pkg::BUS_WRITE)
        begin
          if (state_reg.dp_idx == rcr_pkg::IDX_CTRL0)
          begin
            state_next.supply = hwdata_i[rcr_pkg::SUPPLY_BIT];
            state_next.isel   = hwdata_i[rcr_pkg::ISEL_BIT];
            state_next.run    = hwdata_i[rcr_pkg::RUN_BIT] & hwdata_i[rcr_pkg::SUPPLY_BIT]; // [R19]
          end
          else if (state_reg.dp_idx == rcr_pkg::IDX_CTRL1)
            state_next.mode = hwdata_i[rcr_pkg::MODE_W-1:0]; // [R01]
          else if (state_reg.dp_idx == rcr_pkg::IDX_CNT_A)
            state_next.cnt_a = hwdata_i[rcr_pkg::CNT_A_W-1:0];
          else if (state_reg.dp_idx == rcr_pkg::IDX_CNT_B)
            state_next.cnt_b = hwdata_i[rcr_pkg::CNT_B_W-1:0];
        end
        if (accept)
        begin
          state_next.dp_idx = haddr_i[rcr_pkg::IDX_LSB +: rcr_pkg::IDX_W];
          state_next.bus_st = hwrite_i ? rcr_pkg::BUS_WRITE : rcr_pkg::BUS_RD_WAIT;
        end
        else
          state_next.bus_st = rcr_pkg::BUS_IDLE;
      end
    endcase

    // count-on follows run one clock later and drops with the gate overflow
    state_next.count_on = state_reg.run & state_reg.supply & ~gate_ovf & state_next.run; // [R11] [R21]
    state_next.drive    = state_next.count_on ? osc_decode(state_reg.mode) : '0; // [R01] [R13]
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign hrdata_o        = state_reg.rdata;
  assign hreadyout_o     = (state_reg.bus_st != rcr_pkg::BUS_RD_WAIT);
  assign hresp_o         = rcr_pkg::HRESP_OKAY;
  assign osc_drive_o     = state_reg.drive;
  assign osc_run_o       = state_reg.count_on;
  assign count_on_o      = state_reg.count_on;
  assign converter_irq_o = state_reg.irq;

  wire unused_ok = &{1'b0, hsize_i, haddr_i[31:12], haddr_i[1:0], htrans_i[0]};

endmodule

// *** verif/rcr_osc_model.sv ***
`timescale 1ns/1ns
module rcr_osc_model #(
  parameter int HALF_NS = 40
) (
  input  wire logic run_i,
  output logic      osc_o
);
  // free grid offset from the core clock; stands still low outside a run
  initial
  begin
    osc_o = 1'b0;
    #3;
    forever
    begin
      #HALF_NS;
      if (run_i === 1'b1) osc_o = ~osc_o;
      else osc_o = 1'b0;
    end
  end
endmodule

// *** verif/rcr_ratio_counter_chk.sv ***
`timescale 1ns/1ns
module rcr_ratio_counter_chk (
  input  wire logic               core_clk_i,
  input  wire logic               arst_n_i,
  input  wire logic               hsel_i,
  input  wire logic [1:0]         htrans_i,
  input  wire logic               hwrite_i,
  input  wire logic               hready_i,
  input  wire logic               hreadyout_o,
  input  wire logic               hresp_o,
  input  wire rcr_pkg::rcr_osc_drive_t osc_drive_o,
  input  wire logic               osc_run_o,
  input  wire logic               count_on_o,
  input  wire logic               converter_irq_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_take;
    hsel_i && hready_i && htrans_i[1];
  endsequence
  sequence s_gate_end;
    $fell(count_on_o) ##1 !count_on_o;
  endsequence
  okay_resp_a: assert property (hresp_o == rcr_pkg::HRESP_OKAY) else $error("response not okay");
  rd_wait_a: assert property (s_take and !hwrite_i |=> !hreadyout_o ##1 hreadyout_o) else $error("read wait");
  wr_nowait_a: assert property (s_take and hwrite_i |=> hreadyout_o) else $error("write stalled");
  wait_cause_a: assert property (!hreadyout_o |-> $past(hsel_i && hready_i && htrans_i[1] && !hwrite_i))
    else $error("stray wait state");
  osc_follow_a: assert property (osc_run_o == count_on_o) else $error("osc run differs");
  drive_idle_a: assert property (!count_on_o [*2] |-> osc_drive_o == '0) else $error("drive off run");
  irq_pulse_a: assert property (converter_irq_o |=> !converter_irq_o) else $error("irq too long");
  irq_stop_a: assert property ($rose(converter_irq_o) |-> $fell(count_on_o)) else $error("irq no stop");
  idle_hold_a: assert property (s_gate_end |-> !converter_irq_o) else $error("late irq");
endmodule
bind rcr_ratio_counter rcr_ratio_counter_chk i_chk (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
  .hsel_i(hsel_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .osc_drive_o(osc_drive_o), .osc_run_o(osc_run_o),
  .count_on_o(count_on_o), .converter_irq_o(converter_irq_o));

// *** verif/tb_rcr_ratio_counter.sv ***
`timescale 1ns/1ns
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin err_total++; \
  $display("wrong value %s exp %0h got %0h", nm, e, s); end end
module tb_rcr_ratio_counter;
  logic                    core_clk_i, arst_n_i, hsel, hwrite, hready, hresp, osc, osc_run, count_on, irq, isel;
  logic [1:0]              htrans;
  logic [31:0]             haddr, hwdata, hrdata, q, dummy;
  rcr_pkg::rcr_osc_drive_t drive;
  int                      err_total, n_tests, seed, n, got, expv;
  // expected pin drive per oscillation mode, fields msb first as in the drive struct
  function automatic logic [9:0] exp_drive(input int m);
    logic [9:0] v;
    case (m)
      0: v = 10'h002;
      1: v = 10'h240;
      2: v = 10'h140;
      3: v = 10'h0C0;
      4: v = 10'h220;
      5: v = 10'h014;
      6: v = 10'h00C;
      default: v = 10'h001;
    endcase
    return v;
  endfunction
  rcr_ratio_counter i_rcr_ratio_counter (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .rc_osc_clock_i(osc),
    .osc_drive_o(drive), .osc_run_o(osc_run), .count_on_o(count_on), .converter_irq_o(irq));
  rcr_osc_model u_osc (.run_i(osc_run), .osc_o(osc));
  task complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task xfer(input logic w, input logic [9:0] idx, input logic [31:0] d, output logic [31:0] r);
    int k;
    haddr <= {20'h0_0000, idx, 2'h0}; htrans <= 2'h2; hwrite <= w; hsel <= 1'b1;
    for (int ph = 0; ph < 2; ph++)
    begin
      k = 0;
      do begin @(posedge core_clk_i); k++; end while (hready !== 1'b1 && k < 20);
      if (hready !== 1'b1) begin err_total++; complete_run(); end
      if (ph == 0) begin htrans <= 2'h0; hsel <= 1'b0; hwdata <= d; end
    end
    r = hrdata;
  endtask
  function automatic logic [31:0] to_bcd(input int v);
    logic [31:0] r;
    r = '0;
    for (int i = 0; i < 5; i++) begin r[i*4 +: 4] = 4'(v % 10); v = v / 10; end
    return r;
  endfunction
  function automatic int from_bcd(input logic [31:0] b);
    int acc;
    acc = 0;
    for (int i = 4; i >= 0; i--) acc = acc * 10 + int'(b[i*4 +: 4]);
    return acc;
  endfunction
  task gated_run(input int m);
    int k;
    isel = m[0];
    n = isel ? 10 + ($unsigned($random(seed)) % 32) : 200 + ($unsigned($random(seed)) % 256);
    xfer(1'b1, rcr_pkg::IDX_CTRL1, m, dummy);
    xfer(1'b1, rcr_pkg::IDX_CNT_A, isel ? 32'h0 : to_bcd(80000 - n), dummy);
    xfer(1'b1, rcr_pkg::IDX_CNT_B, isel ? 32'h4000 - n : 32'h0, dummy);
    xfer(1'b1, rcr_pkg::IDX_CTRL0, {29'h0, 1'b1, isel, 1'b1}, dummy);
    xfer(1'b0, rcr_pkg::IDX_CTRL0, 32'h0, q);
    `CHK("run_busy", {29'h0, 1'b1, isel, 1'b1}, q)
    `CHK("osc_drive", exp_drive(m), drive)
    k = 0;
    while (irq !== 1'b1 && k < 2000) begin @(posedge core_clk_i); k++; end
    if (k >= 2000) begin err_total++; complete_run(); end
    xfer(1'b0, rcr_pkg::IDX_CTRL0, 32'h0, q);
    `CHK("run_done", {29'h0, 1'b1, isel, 1'b0}, q)
    `CHK("count_on", 1'b0, count_on)
    xfer(1'b0, isel ? rcr_pkg::IDX_CNT_B : rcr_pkg::IDX_CNT_A, 32'h0, q);
    `CHK("gate_wrap", 32'h0, q)
    xfer(1'b0, isel ? rcr_pkg::IDX_CNT_A : rcr_pkg::IDX_CNT_B, 32'h0, q);
    got = isel ? from_bcd(q) : int'(q);
    expv = isel ? n * 8 : n / 8;
    `CHK("result_cnt", 1'b1, (got >= expv - 10 && got <= expv + 10))
    // the result must stay put once the gate has closed
    repeat (16) @(posedge core_clk_i);
    xfer(1'b0, isel ? rcr_pkg::IDX_CNT_A : rcr_pkg::IDX_CNT_B, 32'h0, dummy);
    `CHK("result_hold", q, dummy)
  endtask
  initial
  begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  initial
  begin
    arst_n_i = 1'b0; hsel = 1'b0; hwrite = 1'b0; htrans = 2'h0; haddr = '0; hwdata = '0;
    err_total = 0; n_tests = 0; seed = 32'hE4A0;
    repeat (6) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      xfer(1'b0, (i == 4) ? 10'h001 : rcr_pkg::IDX_CNT_A + 10'(i), 32'h0, q);
      `CHK("reset_or_unmapped", rcr_pkg::RESET_WORD, q)
    end
    xfer(1'b1, rcr_pkg::IDX_CTRL0, 32'h1, dummy);
    repeat (20) @(posedge core_clk_i);
    xfer(1'b0, rcr_pkg::IDX_CTRL0, 32'h0, q);
    `CHK("no_supply_run", 32'h0, q)
    `CHK("no_supply_on", 1'b0, count_on)
    xfer(1'b1, rcr_pkg::IDX_CTRL0, 32'h4, dummy);
    // supply settling time before the first run
    repeat (12000) @(posedge core_clk_i);
    for (int m = 0; m < 8; m++) gated_run(m);
    complete_run();
  end
endmodule
